// *** hw/rvs_defines.vh ***
// Constants for the reset and voltage supervisor block.
// Assumes an 8-bit special-function-register bus and a 100 MHz sys_clk.
//
// How it works
// - Chip reset comes from power-on, pin, software, watchdog or undervoltage.
// - Any chip reset returns every register here to its default value.
// - After power-on the chip stays in reset about 40 ms of warm-up.
// - In Halt/Stop the power-on detector stays on only if its disable bit, the saving bit and the undervoltage disable bit are all 0.
// - The reset pin is active low; a low of two slow RC cycles is seen.
// - A configuration word bit lets the reset pin act or be ignored.
// - Writing 56h to the software command register resets; other values do not.
// - A two-bit field decides whether watchdog overflow resets the chip.
// - Watchdog counts slow RC ticks; runs in Fast/Slow, runs or stops otherwise.
// - A two-bit prescaler field selects the watchdog overflow period.
// - The watchdog clears when software sets its clear bit, and on reset.
// - A 4-bit undervoltage threshold code goes straight to the comparator.
// - Undervoltage reset disable bit: 0 enables, 1 disables the reset.
// - Enabled undervoltage reset stays on in Fast/Slow; low-power too if saving off.
// - Saving on or reset disabled turns undervoltage reset off in low-power modes.
// - Polarity bit picks whether comparator high or low sets the detect flag.
// - The live detect comparator output reads back unlatched.
// - The hysteresis bit enables comparator hysteresis when set.
// - Detect disable bit: 0 enables; detection forced off in Idle/Halt/Stop.
// - A 4-bit detect threshold code goes straight to the detect comparator.
// - Watchdog reset codes: 0x off, 10 Fast/Slow only, 11 all modes.
// - Prescaler codes 00..11 give 400, 200, 100 and 50 ms periods.
// - The watchdog clear bit returns to zero on the next clock.
`ifndef RVS_DEFINES_VH
`define RVS_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RVS_ADDR_UVR_CTRL   8'hE3
`define RVS_ADDR_DET_CTRL   8'hE4
`define RVS_ADDR_AUX_TWO    8'hF7
`define RVS_ADDR_AUX_ONE    8'hF8
`define RVS_ADDR_OPTION     8'h94
`define RVS_ADDR_SW_CMD     8'h97

// ----------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------
`define RVS_UVR_CTRL_RST    6'h00
`define RVS_DET_CTRL_RST    7'h00
`define RVS_AUX_TWO_RST     8'h06
`define RVS_OPTION_RST      8'h00
`define RVS_SW_RESET_KEY    8'h56

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RVS_UVR_POR_DIS     5
`define RVS_UVR_DIS         4
`define RVS_THR_MSB         3
`define RVS_DET_POL         7
`define RVS_DET_LIVE        6
`define RVS_DET_HYST        5
`define RVS_DET_DIS         4
`define RVS_AUX_WDT_MSB     7
`define RVS_AUX_WDT_LSB     6
`define RVS_AUX_SAVE        5
`define RVS_OPT_PSC_MSB     5
`define RVS_OPT_PSC_LSB     4
`define RVS_AUX_CLR_WDT     7

// ----------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------
`define RVS_MODE_FAST       3'h0
`define RVS_MODE_SLOW       3'h1
`define RVS_MODE_IDLE       3'h2
`define RVS_MODE_HALT       3'h3
`define RVS_MODE_STOP       3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RVS_SYS_CLK_KHZ     100000
`define RVS_WARMUP_MS       40
`define RVS_SRC_HZ          41000
`define RVS_WDT_BASE_MS     400
`define RVS_PIN_LOW_TICKS   2
`define RVS_RST_HOLD        4'h4

`endif

// *** hw/rvs_pin_filter.v ***
// Reset pin synchroniser and low-length qualifier.
// Assumes src_tick is a one-cycle pulse per slow RC clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "rvs_defines.vh"

module rvs_pin_filter (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       src_tick,
  input  wire       pin_n,
  output reg        pin_low_r
);

  reg        sync1_r;
  reg        sync2_r;
  reg  [1:0] low_cnt_r;

  // ----------------------------------------------------------------
  // Two stages on the slow clock, then count low ticks
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      sync1_r   <= 1'b1;
      sync2_r   <= 1'b1;
      low_cnt_r <= 2'h0;
      pin_low_r <= 1'b0;
    end else if (src_tick) begin
      sync1_r <= pin_n;
      sync2_r <= sync1_r;
      if (sync2_r) begin
        low_cnt_r <= 2'h0;
        pin_low_r <= 1'b0;
      end else if (low_cnt_r == (`RVS_PIN_LOW_TICKS - 1)) begin
        pin_low_r <= 1'b1;
      end else begin
        low_cnt_r <= low_cnt_r + 2'h1;
      end
    end
  end

endmodule // rvs_pin_filter
`default_nettype wire

// *** hw/rvs_watchdog.v ***
// Watchdog counter on slow RC ticks with selectable overflow period.
// Assumes src_tick is a one-cycle pulse per slow RC clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "rvs_defines.vh"

module rvs_watchdog #(
  parameter WIDTH      = 16,
  parameter BASE_TICKS = `RVS_WDT_BASE_MS * `RVS_SRC_HZ / 1000
) (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       src_tick,
  input  wire       run,
  input  wire       clear,
  input  wire [1:0] psel,
  output reg        overflow_r
);

  reg  [WIDTH-1:0] count_r;
  wire [WIDTH-1:0] limit;

  // Each code halves the period
  assign limit = BASE_TICKS[WIDTH-1:0] >> psel;

  always @(posedge sys_clk) begin
    if (reset || clear) begin
      count_r    <= {WIDTH{1'b0}};
      overflow_r <= 1'b0;
    end else begin
      overflow_r <= 1'b0;
      if (src_tick && run) begin
        if (count_r >= limit - 1'b1) begin
          count_r    <= {WIDTH{1'b0}};
          overflow_r <= 1'b1;
        end else begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

endmodule // rvs_watchdog
`default_nettype wire

// *** hw/rvs_supervisor.v ***
// Reset and supply supervisor: source merge, warm-up, thresholds, registers.
// Assumes analog comparators, pin and slow RC clock are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "rvs_defines.vh"

module rvs_supervisor #(
  parameter WARMUP_CYCLES = `RVS_WARMUP_MS * `RVS_SYS_CLK_KHZ,
  parameter WDT_TICKS     = `RVS_WDT_BASE_MS * `RVS_SRC_HZ / 1000,
  parameter WDT_WIDTH     = 16
) (
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       src_clk,
  input  wire [2:0] op_mode,
  input  wire       cfg_pin_reset_enable,
  input  wire       ext_reset_n,
  input  wire       por_detect,
  input  wire       uvr_trip,
  input  wire       detect_cmp_out,
  input  wire       detect_event_clear,
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata_r,
  output reg        chip_reset_r,
  output reg        por_enable_r,
  output reg        uvr_enable_r,
  output reg  [3:0] uvr_threshold_r,
  output reg        det_enable_r,
  output reg        det_hyst_r,
  output reg  [3:0] det_threshold_r,
  output reg        detect_event_flag_r
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_run_mode;
    input [2:0] mode;
    begin
      is_run_mode = (mode == `RVS_MODE_FAST) || (mode == `RVS_MODE_SLOW);
    end
  endfunction

  function is_addr;
    input [7:0] addr;
    input [7:0] target;
    begin
      is_addr = (addr == target);
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [5:0]  uvr_ctrl_r;
  reg  [6:0]  det_ctrl_r;
  reg  [7:0]  aux_two_r;
  reg  [7:0]  option_r;
  reg         wdt_clear_r;
  reg         sw_req_r;
  reg         src_prev_r;
  reg  [31:0] warm_cnt_r;
  reg  [3:0]  hold_cnt_r;
  reg         det_cond_prev_r;
  reg  [7:0]  rdata_nxt;

  wire        src_tick;
  wire        run_mode;
  wire        halt_stop;
  wire        reg_reset;
  wire        pin_low;
  wire        wdt_overflow;
  wire        wdt_run;
  wire        wdt_rst_en;
  wire        save_bit;
  wire        por_en_nxt;
  wire        uvr_en_nxt;
  wire        det_en_nxt;
  wire        det_cond;
  wire        por_req;
  wire        pin_req;
  wire        wdt_req;
  wire        uvr_req;
  wire        any_req;

  // ----------------------------------------------------------------
  // Mode decode and slow clock edge
  // ----------------------------------------------------------------
  assign src_tick  = src_clk & ~src_prev_r;
  assign run_mode  = is_run_mode(op_mode);
  assign halt_stop = (op_mode == `RVS_MODE_HALT) || (op_mode == `RVS_MODE_STOP);
  assign save_bit  = aux_two_r[`RVS_AUX_SAVE];

  // Registers fall back to defaults under any chip reset
  assign reg_reset = reset | chip_reset_r;

  always @(posedge sys_clk) begin
    if (reset) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_clk;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reg_reset) begin
      uvr_ctrl_r  <= `RVS_UVR_CTRL_RST;
      det_ctrl_r  <= `RVS_DET_CTRL_RST;
      aux_two_r   <= `RVS_AUX_TWO_RST;
      option_r    <= `RVS_OPTION_RST;
      wdt_clear_r <= 1'b0;
      sw_req_r    <= 1'b0;
    end else begin
      wdt_clear_r <= 1'b0;
      sw_req_r    <= 1'b0;
      if (sfr_wr) begin
        if (is_addr(sfr_addr, `RVS_ADDR_UVR_CTRL)) begin
          uvr_ctrl_r <= sfr_wdata[5:0];
        end
        if (is_addr(sfr_addr, `RVS_ADDR_DET_CTRL)) begin
          det_ctrl_r <= {sfr_wdata[`RVS_DET_POL], sfr_wdata[5:0]};
        end
        if (is_addr(sfr_addr, `RVS_ADDR_AUX_TWO)) begin
          aux_two_r <= sfr_wdata;
        end
        if (is_addr(sfr_addr, `RVS_ADDR_OPTION)) begin
          option_r <= sfr_wdata;
        end
        if (is_addr(sfr_addr, `RVS_ADDR_AUX_ONE)) begin
          wdt_clear_r <= sfr_wdata[`RVS_AUX_CLR_WDT];
        end
        if (is_addr(sfr_addr, `RVS_ADDR_SW_CMD)) begin
          sw_req_r <= (sfr_wdata == `RVS_SW_RESET_KEY);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read-back, registered; unmapped and write-only read as zero
  // ----------------------------------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    if (is_addr(sfr_addr, `RVS_ADDR_UVR_CTRL)) begin
      rdata_nxt = {2'h0, uvr_ctrl_r};
    end else if (is_addr(sfr_addr, `RVS_ADDR_DET_CTRL)) begin
      rdata_nxt = {det_ctrl_r[`RVS_DET_POL-1], detect_cmp_out, det_ctrl_r[5:0]};
    end else if (is_addr(sfr_addr, `RVS_ADDR_AUX_TWO)) begin
      rdata_nxt = aux_two_r;
    end else if (is_addr(sfr_addr, `RVS_ADDR_OPTION)) begin
      rdata_nxt = option_r;
    end else if (is_addr(sfr_addr, `RVS_ADDR_AUX_ONE)) begin
      rdata_nxt = {wdt_clear_r, 7'h00};
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Enables for the analog side
  // ----------------------------------------------------------------
  // Power-on detector always on outside Halt/Stop
  assign por_en_nxt = ~halt_stop |
                      (~uvr_ctrl_r[`RVS_UVR_POR_DIS] &
                       ~save_bit & ~uvr_ctrl_r[`RVS_UVR_DIS]);
  assign uvr_en_nxt = ~uvr_ctrl_r[`RVS_UVR_DIS] & (run_mode | ~save_bit);
  assign det_en_nxt = ~det_ctrl_r[`RVS_DET_DIS] & run_mode;

  always @(posedge sys_clk) begin
    if (reg_reset) begin
      por_enable_r    <= 1'b1;
      uvr_enable_r    <= 1'b1;
      uvr_threshold_r <= 4'h0;
      det_enable_r    <= 1'b0;
      det_hyst_r      <= 1'b0;
      det_threshold_r <= 4'h0;
    end else begin
      por_enable_r    <= por_en_nxt;
      uvr_enable_r    <= uvr_en_nxt;
      uvr_threshold_r <= uvr_ctrl_r[`RVS_THR_MSB:0];
      det_enable_r    <= det_en_nxt;
      det_hyst_r      <= det_ctrl_r[`RVS_DET_HYST];
      det_threshold_r <= det_ctrl_r[`RVS_THR_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Detect event flag
  // ----------------------------------------------------------------
  // Polarity bit sits at index 6 of the packed copy
  assign det_cond = det_en_nxt & (detect_cmp_out ^ det_ctrl_r[`RVS_DET_POL-1]);

  always @(posedge sys_clk) begin
    if (reg_reset) begin
      det_cond_prev_r     <= 1'b0;
      detect_event_flag_r <= 1'b0;
    end else begin
      det_cond_prev_r <= det_cond;
      // Set wins over a clear in the same cycle
      if (det_cond && !det_cond_prev_r) begin
        detect_event_flag_r <= 1'b1;
      end else if (detect_event_clear) begin
        detect_event_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin and watchdog sources
  // ----------------------------------------------------------------
  // Filter is not cleared by chip reset, or a held pin would release early
  rvs_pin_filter u_pin (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .src_tick  (src_tick),
    .pin_n     (ext_reset_n),
    .pin_low_r (pin_low)
  );

  assign wdt_rst_en = aux_two_r[`RVS_AUX_WDT_MSB] &
                      (aux_two_r[`RVS_AUX_WDT_LSB] | run_mode);
  // Counting in low-power modes only when the reset stays armed there
  assign wdt_run    = run_mode | (aux_two_r[`RVS_AUX_WDT_MSB] &
                                  aux_two_r[`RVS_AUX_WDT_LSB]);

  rvs_watchdog #(
    .WIDTH      (WDT_WIDTH),
    .BASE_TICKS (WDT_TICKS)
  ) u_wdt (
    .sys_clk    (sys_clk),
    .reset      (reg_reset),
    .src_tick   (src_tick),
    .run        (wdt_run),
    .clear      (wdt_clear_r),
    .psel       (option_r[`RVS_OPT_PSC_MSB:`RVS_OPT_PSC_LSB]),
    .overflow_r (wdt_overflow)
  );

  // ----------------------------------------------------------------
  // Source merge, warm-up and hold
  // ----------------------------------------------------------------
  assign por_req = por_enable_r & por_detect;
  assign pin_req = cfg_pin_reset_enable & pin_low;
  assign wdt_req = wdt_rst_en & wdt_overflow;
  assign uvr_req = uvr_enable_r & uvr_trip;
  assign any_req = por_req | pin_req | sw_req_r | wdt_req | uvr_req;

  // Warm-up restarts whenever the supply dips to a power-on event
  always @(posedge sys_clk) begin
    if (reset || por_req) begin
      warm_cnt_r <= WARMUP_CYCLES;
    end else if (warm_cnt_r != 32'h0) begin
      warm_cnt_r <= warm_cnt_r - 32'h1;
    end
  end

  // Short stretch so one-cycle sources still reset every register
  always @(posedge sys_clk) begin
    if (reset) begin
      hold_cnt_r <= `RVS_RST_HOLD;
    end else if (any_req) begin
      hold_cnt_r <= `RVS_RST_HOLD;
    end else if (hold_cnt_r != 4'h0) begin
      hold_cnt_r <= hold_cnt_r - 4'h1;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      chip_reset_r <= 1'b1;
    end else begin
      chip_reset_r <= any_req | (hold_cnt_r != 4'h0) | (warm_cnt_r != 32'h0);
    end
  end

endmodule // rvs_supervisor
`default_nettype wire

// *** hw/rvs_end.v ***
`default_nettype wire

// *** tb/rvs_checker.sv ***
// Port assertions for the reset and voltage supervisor.
// Assumes binding onto rvs_supervisor: one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module rvs_checker (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [2:0] op_mode,
  input wire logic       uvr_trip,
  input wire logic       detect_cmp_out,
  input wire logic       detect_event_clear,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic       chip_reset_r,
  input wire logic       uvr_enable_r,
  input wire logic [3:0] uvr_threshold_r,
  input wire logic       det_enable_r,
  input wire logic       det_hyst_r,
  input wire logic [3:0] det_threshold_r,
  input wire logic       detect_event_flag_r
);
  wire logic wr_ok = sfr_wr && !chip_reset_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_hold; $fell(reset) |-> chip_reset_r [*8]; endproperty
  a_hold: assert property (p_hold) else $error("warm-up hold too short");
  property p_uvr; uvr_enable_r && uvr_trip |-> ##[1:2] chip_reset_r; endproperty
  a_uvr: assert property (p_uvr) else $error("undervoltage did not reset");
  property p_sw; wr_ok && sfr_addr == 8'h97 && sfr_wdata == 8'h56 |-> ##[1:3] chip_reset_r;
  endproperty
  a_sw: assert property (p_sw) else $error("software key did not reset");
  property p_uthr; wr_ok && sfr_addr == 8'hE3 |-> ##2
    (chip_reset_r || uvr_threshold_r == $past(sfr_wdata[3:0], 2)); endproperty
  a_uthr: assert property (p_uthr) else $error("undervoltage code not forwarded");
  property p_dthr; wr_ok && sfr_addr == 8'hE4 |-> ##2 (chip_reset_r ||
    {det_hyst_r, det_threshold_r} == {$past(sfr_wdata[5], 2), $past(sfr_wdata[3:0], 2)});
  endproperty
  a_dthr: assert property (p_dthr) else $error("detect code not forwarded");
  property p_live; sfr_rd && sfr_addr == 8'hE4 && !chip_reset_r |=>
    sfr_rdata_r[6] == $past(detect_cmp_out); endproperty
  a_live: assert property (p_live) else $error("live comparator bit wrong");
  property p_cmd; sfr_rd && sfr_addr == 8'h97 && !chip_reset_r |=> sfr_rdata_r == 8'h00;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command register read not zero");
  property p_detoff; op_mode >= 3'h2 |=> !det_enable_r; endproperty
  a_detoff: assert property (p_detoff) else $error("detect on in low-power mode");
  property p_flag; detect_event_flag_r && !detect_event_clear && !chip_reset_r |=>
    detect_event_flag_r; endproperty
  a_flag: assert property (p_flag) else $error("event flag lost");
  c_sw: cover property (wr_ok && sfr_addr == 8'h97 && sfr_wdata == 8'h56);
  c_flag: cover property ($rose(detect_event_flag_r));
  c_uvr: cover property (uvr_enable_r && uvr_trip);
endmodule // rvs_checker
bind rvs_supervisor rvs_checker u_chk (.sys_clk, .reset, .op_mode, .uvr_trip,
  .detect_cmp_out, .detect_event_clear, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata_r, .chip_reset_r, .uvr_enable_r, .uvr_threshold_r, .det_enable_r,
  .det_hyst_r, .det_threshold_r, .detect_event_flag_r);
`default_nettype wire

// *** tb/rvs_far_model.sv ***
// Far side: free RC oscillator, reset pin, supply comparators.
// Assumes the bench sets vcc_level and calls the pin and power tasks.
`timescale 1ns/1ps
`default_nettype none
module rvs_far_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] uvr_threshold_r,
  input  wire logic       uvr_enable_r,
  input  wire logic [3:0] det_threshold_r,
  output logic            src_clk,
  output logic            ext_reset_n,
  output logic            por_detect,
  output logic            uvr_trip,
  output logic            detect_cmp_out
);
  integer vcc_level;
  integer div;
  initial begin
    vcc_level = 31;
    div = 0;
    src_clk = 1'b0;
    ext_reset_n = 1'b1;
    por_detect = 1'b0;
  end
  // RC oscillator runs free, one tick per 8 sys cycles
  always @(posedge sys_clk) begin
    div <= (div + 1) % 8;
    src_clk <= (div >= 4);
  end
  // Comparator unpowered when disabled, so it never trips
  assign uvr_trip = uvr_enable_r && (vcc_level < uvr_threshold_r);
  assign detect_cmp_out = (vcc_level < det_threshold_r);
  task pin_low(input integer ticks);
    ext_reset_n = 1'b0;
    repeat (ticks + 1) @(posedge src_clk);
    @(posedge sys_clk);
    #1 ext_reset_n = 1'b1;
  endtask
  task por_pulse;
    @(posedge sys_clk);
    #1 por_detect = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 por_detect = 1'b0;
  endtask
endmodule // rvs_far_model
`default_nettype wire

// *** tb/rvs_supervisor_bench.sv ***
// Self-checking bench for the reset and voltage supervisor.
// Assumes the far model supplies RC clock, pin and comparators.
`timescale 1ns/1ps
`default_nettype none
module rvs_supervisor_bench;
  logic        sys_clk, reset, src_clk, ext_reset_n, por_detect, uvr_trip;
  logic        detect_cmp_out, cfg_pin_reset_enable, detect_event_clear;
  logic        sfr_wr, sfr_rd, chip_reset_r, por_enable_r, uvr_enable_r;
  logic        det_enable_r, det_hyst_r, detect_event_flag_r;
  logic [2:0]  op_mode;
  logic [3:0]  uvr_threshold_r, det_threshold_r;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_r, a, d;
  logic [7:0]  mreg [int];
  logic [7:0]  al [7] = '{8'hE3, 8'hE4, 8'hF7, 8'h94, 8'h97, 8'h80, 8'hF8};
  logic [7:0]  tcode [3] = '{8'h05, 8'h16, 8'h06};
  logic [7:0]  wcode [3] = '{8'hC0, 8'h80, 8'h40};
  logic [31:0] rnd = 32'h42577987;
  int          failures = 0, cmp_count = 0, cyc = 0, held, took, k, m, p;

  rvs_supervisor #(.WARMUP_CYCLES(50), .WDT_TICKS(16), .WDT_WIDTH(16)) dut (
    .sys_clk(sys_clk), .reset(reset), .src_clk(src_clk), .op_mode(op_mode),
    .cfg_pin_reset_enable(cfg_pin_reset_enable), .ext_reset_n(ext_reset_n),
    .por_detect(por_detect), .uvr_trip(uvr_trip), .detect_cmp_out(detect_cmp_out),
    .detect_event_clear(detect_event_clear), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .chip_reset_r(chip_reset_r), .por_enable_r(por_enable_r),
    .uvr_enable_r(uvr_enable_r), .uvr_threshold_r(uvr_threshold_r),
    .det_enable_r(det_enable_r), .det_hyst_r(det_hyst_r),
    .det_threshold_r(det_threshold_r), .detect_event_flag_r(detect_event_flag_r));
  rvs_far_model far (.sys_clk(sys_clk), .uvr_threshold_r(uvr_threshold_r),
    .uvr_enable_r(uvr_enable_r), .det_threshold_r(det_threshold_r),
    .src_clk(src_clk), .ext_reset_n(ext_reset_n), .por_detect(por_detect),
    .uvr_trip(uvr_trip), .detect_cmp_out(detect_cmp_out));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard, run needs well under this
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic defaults;
    mreg.delete();
    mreg[8'hE3] = 8'h00;
    mreg[8'hE4] = 8'h00;
    mreg[8'hF7] = 8'h06;
    mreg[8'h94] = 8'h00;
  endtask
  task automatic sfr_write(input logic [7:0] wa, input logic [7:0] wd);
    @(posedge sys_clk);
    #1 sfr_addr = wa;
    sfr_wdata = wd;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #1 sfr_wr = 1'b0;
    if (mreg.exists(wa)) mreg[wa] = wd & (wa == 8'hE3 ? 8'h3F : wa == 8'hE4 ? 8'hBF : 8'hFF);
  endtask
  task automatic sfr_check(input logic [7:0] ra);
    logic [7:0] e;
    @(posedge sys_clk);
    #1 sfr_addr = ra;
    sfr_rd = 1'b1;
    e = mreg.exists(ra) ? mreg[ra] : 8'h00;
    if (ra == 8'hE4) e[6] = detect_cmp_out;
    @(posedge sys_clk);
    #1 sfr_rd = 1'b0;
    chk("rdata", sfr_rdata_r, e);
    chk("uvr_thr", uvr_threshold_r, mreg[8'hE3][3:0]);
    chk("det_thr", det_threshold_r, mreg[8'hE4][3:0]);
    chk("det_hyst", det_hyst_r, mreg[8'hE4][5]);
  endtask
  task automatic expect_rst(input int max, input logic want);
    logic got;
    got = 1'b0;
    took = 0;
    held = 0;
    while (took < max && !got) begin
      @(posedge sys_clk);
      #1 took++;
      got = (chip_reset_r === 1'b1);
    end
    chk("chip_reset", got, want);
    while (chip_reset_r !== 1'b0 && held < 400) begin
      @(posedge sys_clk);
      #1 held++;
    end
    chk("release", held < 400, 1);
    if (got) defaults();
  endtask
  task automatic clear_flag;
    @(posedge sys_clk);
    #1 detect_event_clear = 1'b1;
    @(posedge sys_clk);
    #1 detect_event_clear = 1'b0;
    @(posedge sys_clk);
    #1 chk("flag", detect_event_flag_r, 0);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    op_mode = 3'h0;
    cfg_pin_reset_enable = 1'b0;
    detect_event_clear = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    expect_rst(2, 1);
    chk("warmup", held >= 50 && held <= 52, 1);
    for (k = 0; k < 7; k++) sfr_check(al[k]);
    for (k = 0; k < 24; k++) begin
      rnd = xs(rnd);
      a = al[rnd[1:0]];
      d = rnd[15:8];
      if (a == 8'hF7) d[7] = 1'b0; // Keeps the watchdog reset off here
      sfr_write(a, d);
      sfr_check(a);
    end
    for (k = 0; k < 8; k++) begin
      sfr_write(8'hE3, {2'b00, k[1], k[0], 4'h0});
      sfr_write(8'hF7, {2'b00, k[2], 5'h00});
      sfr_write(8'hE4, {3'b000, k[0], 4'h0});
      for (m = 0; m < 5; m++) begin
        @(posedge sys_clk);
        #1 op_mode = m[2:0];
        repeat (2) @(posedge sys_clk);
        #1 chk("uvr_en", uvr_enable_r, !k[0] && (m < 2 || !k[2]));
        chk("por_en", por_enable_r, m < 3 || (!k[0] && !k[1] && !k[2]));
        chk("det_en", det_enable_r, !k[0] && m < 2);
      end
      op_mode = 3'h0;
    end
    far.vcc_level = 5;
    for (k = 0; k < 3; k++) begin
      sfr_write(8'hE3, tcode[k]);
      expect_rst(10, k == 2);
    end
    far.vcc_level = 31;
    for (p = 0; p < 2; p++) begin
      far.vcc_level = p ? 4 : 31;
      sfr_write(8'hE4, {p[0], 7'h08});
      clear_flag();
      far.vcc_level = p ? 31 : 4;
      repeat (3) @(posedge sys_clk);
      #1 chk("flag", detect_event_flag_r, 1);
      sfr_check(8'hE4);
      far.vcc_level = p ? 4 : 31;
      repeat (3) @(posedge sys_clk);
      #1 chk("flag", detect_event_flag_r, 1);
      clear_flag();
    end
    far.vcc_level = 31;
    sfr_write(8'hE3, 8'h2A);
    sfr_write(8'h97, 8'h55);
    expect_rst(8, 0);
    sfr_check(8'hE3);
    sfr_write(8'h97, 8'h56);
    expect_rst(4, 1);
    sfr_check(8'hE3);
    for (p = 0; p < 4; p++) begin
      sfr_write(8'h94, {2'b00, p[1:0], 4'h0});
      sfr_write(8'hF7, 8'h80);
      sfr_write(8'hF8, 8'h80);
      expect_rst((16 >> p) * 8 + 40, 1);
      chk("wdt_period", took >= ((16 >> p) - 1) * 8 - 4, 1);
    end
    sfr_write(8'hF7, 8'h80);
    for (k = 0; k < 6; k++) begin
      sfr_write(8'hF8, 8'h80);
      expect_rst(80, 0);
    end
    for (k = 0; k < 3; k++) begin
      op_mode = k < 2 ? 3'h2 : 3'h0;
      sfr_write(8'hF7, wcode[k]);
      sfr_write(8'hF8, 8'h80);
      expect_rst(300, k == 0);
    end
    op_mode = 3'h0;
    sfr_write(8'hF7, 8'h00);
    for (p = 0; p < 2; p++) begin
      cfg_pin_reset_enable = p[0];
      fork
        far.pin_low(2);
        expect_rst(80, p == 1);
      join
    end
    far.por_pulse();
    expect_rst(4, 1);
    chk("warmup", held >= 50 && held <= 52, 1);
    tally_and_finish();
  end
endmodule // rvs_supervisor_bench
`default_nettype wire
